//--- verilog/mlp_pin_interface.sv
// led outputs, station management master and mii receive pins with muxing
// assumes phy status and debug signals on ref_clk; pins asynchronous
// Function
// - The speed indicator is low in 100 Mb/s mode and high in 10 Mb/s mode.
// - The duplex indicator is low in full duplex and high in half duplex without collision.
// - In half duplex the duplex indicator goes low whenever a collision is seen.
// - Management data is launched on the falling and sampled on the rising management clock edge.
// - The management clock runs at 1.5 MHz.
// - Management frames follow the standard preamble, start, opcode, address, turnaround, data.
// - Port-1 select bits route the management pins to the function or to port 1 bits.
// - The debug select bit routes the speed and duplex pins to leds or debug clock and data.
// - The receive clock alone times capture of receive nibble, valid and error.
// - Port-2 select bits route the receive pins to the mii function or to port 2 bits.
// - The link indicator is low while link is up and blinks during activity.
`timescale 1ns/1ps
`include "mlp_consts.svh"

module mlp_pin_interface #(
  parameter int DW = 16,
  parameter int AW = 8,
  parameter int BLINK_HALF = `MLP_BLINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DW-1:0] regRdData,
  input wire logic phySpeed100,
  input wire logic phyFullDuplex,
  input wire logic phyCollision,
  input wire logic phyLinkUp,
  input wire logic phyActivity,
  input wire logic debugClockOut,
  input wire logic debugDataOut,
  output logic speedIndicatorN,
  output logic duplexCollisionIndicatorN,
  output logic linkActivityIndicatorN,
  output logic mgmtClockPin,
  input wire logic mgmtDataIn,
  output logic mgmtDataOut,
  output logic mgmtDataOe,
  input wire logic rxClk,
  input wire logic [3:0] miiReceiveNibble,
  input wire logic rxDataValid,
  input wire logic rxError,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic rxByteErr
);
  localparam logic [5:0] MDC_HALF = 6'(`MLP_MDC_HALF);
  localparam int BW = $clog2(BLINK_HALF + 1);

  logic debugPinSelect;
  mlp_pkg::mlp_psel_t port1PinSelect;
  mlp_pkg::mlp_psel_t port2PinSelect;
  logic [4:0] mgmtPhy;
  logic [4:0] mgmtReg;
  logic mgmtRead;
  logic [15:0] mgmtWrData;
  logic [15:0] mgmtRdData;
  logic [1:0] port1Out;
  logic [1:0] port1Oe;
  mlp_pkg::mlp_mgmt_state_t state;
  logic [5:0] divCnt;
  logic mdcInt;
  logic [5:0] bitIdx;
  logic [63:0] shReg;
  logic mdioOutInt;
  logic mdioOeInt;
  logic [15:0] rdShift;
  logic [1:0] mdioSync;
  logic [3:0] port2Sync0;
  logic [3:0] port2Sync1;
  logic [2:0] togSync;
  logic [7:0] rxCount;
  logic [7:0] byteHold;
  logic errHold;
  logic byteToggle;
  logic [BW-1:0] blinkCnt;
  logic blinkPhase;
  logic startCmd;
  logic p1Func;
  logic p2Func;

  function automatic logic [63:0] mlp_frame(input logic rd, input logic [4:0] phy,
                                            input logic [4:0] rg, input logic [15:0] data);
    logic [1:0] op;
    logic [1:0] ta;
    op = rd ? `MLP_OP_READ : `MLP_OP_WRITE;
    ta = rd ? 2'h3 : `MLP_TA_WRITE;
    mlp_frame = {32'hffffffff, `MLP_FRAME_ST, op, phy, rg, ta, rd ? 16'h0000 : data};
  endfunction

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
    hit = (a == AW'(ofs));
  endfunction

  assign p1Func = (port1PinSelect == `MLP_PSEL_FUNC);
  assign p2Func = (port2PinSelect == `MLP_PSEL_FUNC);
  // a command written while a frame runs is ignored
  assign startCmd = regWrite && hit(regAddr, `MLP_OFS_MGMT_CMD)
                    && regWrData[`MLP_CMD_START_BIT] && (state == mlp_pkg::MLP_MG_IDLE);

  // configuration written by software from the eeprom image
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      debugPinSelect <= `MLP_RST_DBG;
      port1PinSelect <= `MLP_RST_PSEL;
      port2PinSelect <= `MLP_RST_PSEL;
      port1Out <= `MLP_RST_PORT1;
      port1Oe <= `MLP_RST_PORT1;
      mgmtWrData <= 16'h0000;
      mgmtPhy <= 5'h00;
      mgmtReg <= 5'h00;
      mgmtRead <= 1'h0;
    end
    else if (regWrite)
    begin
      if (hit(regAddr, `MLP_OFS_DBG_CFG))
        debugPinSelect <= regWrData[0];
      else if (hit(regAddr, `MLP_OFS_PIN_CFG))
      begin
        port1PinSelect <= regWrData[`MLP_PIN_P1_LSB +: 2];
        port2PinSelect <= regWrData[`MLP_PIN_P2_LSB +: 2];
      end
      else if (startCmd)
      begin
        mgmtReg <= regWrData[`MLP_CMD_REG_LSB +: 5];
        mgmtPhy <= regWrData[`MLP_CMD_PHY_LSB +: 5];
        mgmtRead <= regWrData[`MLP_CMD_READ_BIT];
      end
      else if (hit(regAddr, `MLP_OFS_MGMT_WDATA) && state == mlp_pkg::MLP_MG_IDLE)
        mgmtWrData <= regWrData[15:0];
      else if (hit(regAddr, `MLP_OFS_PORT1))
      begin
        port1Out <= regWrData[`MLP_P1_OUT_LSB +: 2];
        port1Oe <= regWrData[`MLP_P1_OE_LSB +: 2];
      end
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regRdData <= '0;
    else if (!regRead)
      regRdData <= '0;
    else if (hit(regAddr, `MLP_OFS_DBG_CFG))
      regRdData <= DW'(debugPinSelect);
    else if (hit(regAddr, `MLP_OFS_PIN_CFG))
      regRdData <= DW'({port2PinSelect, port1PinSelect});
    else if (hit(regAddr, `MLP_OFS_MGMT_CMD))
      regRdData <= DW'(state == mlp_pkg::MLP_MG_SHIFT);
    else if (hit(regAddr, `MLP_OFS_MGMT_WDATA))
      regRdData <= DW'(mgmtWrData);
    else if (hit(regAddr, `MLP_OFS_MGMT_RDATA))
      regRdData <= DW'(mgmtRdData);
    else if (hit(regAddr, `MLP_OFS_PORT1))
      regRdData <= DW'({mdioSync[1], port1Oe, port1Out});
    else if (hit(regAddr, `MLP_OFS_PORT2_IN))
      regRdData <= DW'(port2Sync1);
    else if (hit(regAddr, `MLP_OFS_RX_STAT))
      regRdData <= DW'({rxCount, rxByte});
    else
      regRdData <= '0;
  end

  // pin inputs pass two flops before use
  always_ff @(posedge ref_clk)
  begin
    mdioSync <= {mdioSync[0], mgmtDataIn};
    port2Sync0 <= miiReceiveNibble;
    port2Sync1 <= port2Sync0;
  end

  // management master: data changes on the falling clock, phy samples on the rise
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= mlp_pkg::MLP_MG_IDLE;
      divCnt <= 6'h00;
      mdcInt <= 1'h0;
      bitIdx <= 6'h00;
      shReg <= 64'h0;
      mdioOutInt <= 1'h0;
      mdioOeInt <= 1'h0;
      rdShift <= 16'h0000;
      mgmtRdData <= 16'h0000;
    end
    else
    begin
      case (state)
        mlp_pkg::MLP_MG_IDLE:
        begin
          mdcInt <= 1'h0;
          divCnt <= 6'h00;
          if (startCmd)
          begin
            shReg <= mlp_frame(regWrData[`MLP_CMD_READ_BIT],
                               regWrData[`MLP_CMD_PHY_LSB +: 5],
                               regWrData[`MLP_CMD_REG_LSB +: 5], mgmtWrData);
            mdioOutInt <= 1'h1;
            mdioOeInt <= 1'h1;
            bitIdx <= 6'h00;
            state <= mlp_pkg::MLP_MG_SHIFT;
          end
        end
        mlp_pkg::MLP_MG_SHIFT:
        begin
          if (divCnt == MDC_HALF - 6'h01)
          begin
            divCnt <= 6'h00;
            mdcInt <= ~mdcInt;
            if (!mdcInt)
            begin
              if (bitIdx >= `MLP_DATA_IDX)
                rdShift <= {rdShift[14:0], mdioSync[1]};
            end
            else if (bitIdx == `MLP_LAST_IDX)
            begin
              state <= mlp_pkg::MLP_MG_IDLE;
              mdioOeInt <= 1'h0;
              if (mgmtRead)
                mgmtRdData <= rdShift;
            end
            else
            begin
              bitIdx <= bitIdx + 6'h01;
              mdioOutInt <= shReg[62];
              shReg <= {shReg[62:0], 1'h0};
              // release the line from the first turnaround bit on, before the phy drives the second
              if (mgmtRead && (bitIdx + 6'h01) == `MLP_TA_IDX)
                mdioOeInt <= 1'h0;
            end
          end
          else
            divCnt <= divCnt + 6'h01;
        end
        default:
          state <= mlp_pkg::MLP_MG_IDLE;
      endcase
    end
  end

  // pins follow the internal copies one cycle later, so clock and data keep their phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mgmtClockPin <= 1'h0;
      mgmtDataOut <= 1'h0;
      mgmtDataOe <= 1'h0;
    end
    else if (p1Func)
    begin
      mgmtClockPin <= mdcInt;
      mgmtDataOut <= mdioOutInt;
      mgmtDataOe <= mdioOeInt;
    end
    else
    begin
      mgmtClockPin <= port1Out[0];
      mgmtDataOut <= port1Out[1];
      mgmtDataOe <= port1Oe[1];
    end
  end

  // blink runs only while there is activity
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !phyActivity)
    begin
      blinkCnt <= '0;
      blinkPhase <= 1'h0;
    end
    else if (blinkCnt == BW'(BLINK_HALF - 1))
    begin
      blinkCnt <= '0;
      blinkPhase <= ~blinkPhase;
    end
    else
      blinkCnt <= blinkCnt + BW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      speedIndicatorN <= 1'h1;
      duplexCollisionIndicatorN <= 1'h1;
      linkActivityIndicatorN <= 1'h1;
    end
    else
    begin
      if (debugPinSelect)
      begin
        speedIndicatorN <= debugClockOut;
        duplexCollisionIndicatorN <= debugDataOut;
      end
      else
      begin
        speedIndicatorN <= !phySpeed100;
        duplexCollisionIndicatorN <= !(phyFullDuplex || phyCollision);
      end
      linkActivityIndicatorN <= !phyLinkUp || (phyActivity && blinkPhase);
    end
  end

  mlp_rx_capture u_rx (
    .rxClk(rxClk),
    .rst_n(rst_n),
    .enable(p2Func),
    .miiReceiveNibble(miiReceiveNibble),
    .rxDataValid(rxDataValid),
    .rxError(rxError),
    .byteHold(byteHold),
    .errHold(errHold),
    .byteToggle(byteToggle)
  );

  // toggle crossing; the held byte is stable for two receive clocks, well past the sync delay
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      togSync <= 3'h0;
      rxByte <= 8'h00;
      rxByteValid <= 1'h0;
      rxByteErr <= 1'h0;
      rxCount <= 8'h00;
    end
    else
    begin
      togSync <= {togSync[1:0], byteToggle};
      rxByteValid <= togSync[2] ^ togSync[1];
      if (togSync[2] ^ togSync[1])
      begin
        rxByte <= byteHold;
        rxByteErr <= errHold;
        rxCount <= rxCount + 8'h01;
      end
    end
  end

  logic [5:0] mdcHiCnt;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mdcHiCnt <= 6'h00;
    else
      mdcHiCnt <= mdcInt ? mdcHiCnt + 6'h01 : 6'h00;
  end

  speed_led_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!debugPinSelect && phySpeed100) |=> !speedIndicatorN)
    else $error("speed indicator not low at 100 Mb/s");
  duplex_led_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!debugPinSelect && !phyFullDuplex && !phyCollision) |=> duplexCollisionIndicatorN)
    else $error("duplex indicator not high in half duplex");
  collision_led_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!debugPinSelect && !phyFullDuplex && phyCollision) |=> !duplexCollisionIndicatorN)
    else $error("collision not shown");
  debug_mux_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    debugPinSelect |=> (speedIndicatorN == $past(debugClockOut)))
    else $error("debug clock not routed");
  mdc_half_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(mdcInt) |-> (mdcHiCnt == MDC_HALF))
    else $error("management clock high phase wrong");
  mdio_launch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(mdcInt) |-> $stable(mdioOutInt))
    else $error("data moved at rising management clock");
  mdc_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == mlp_pkg::MLP_MG_IDLE) |=> !mdcInt)
    else $error("management clock runs outside a frame");
  mdio_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startCmd |=> (mdioOeInt && mdioOutInt) [*2])
    else $error("preamble not driven");
  mgmt_route_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    p1Func |=> (mgmtClockPin == $past(mdcInt)))
    else $error("management clock not routed to pin");
  link_steady_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (phyLinkUp && !phyActivity) |=> !linkActivityIndicatorN)
    else $error("link indicator not low with link up");
endmodule

//--- verilog/mlp_consts.svh
// constants for the management, led and receive pin block
// assumes ref_clk at 100 MHz and a plain register port with byte-wide addresses
`ifndef MLP_CONSTS_SVH
`define MLP_CONSTS_SVH

`define MLP_REF_CLK_KHZ 100000
`define MLP_MDC_FREQ_KHZ 1500
// longest half period, rounded down so the clock never runs slow
`define MLP_MDC_HALF (`MLP_REF_CLK_KHZ / (2 * `MLP_MDC_FREQ_KHZ))
`define MLP_BLINK_HALF_MS 50
`define MLP_BLINK_HALF_CYC (`MLP_BLINK_HALF_MS * `MLP_REF_CLK_KHZ)

`define MLP_OFS_DBG_CFG 8'h01
`define MLP_OFS_PIN_CFG 8'h02
`define MLP_OFS_MGMT_CMD 8'h03
`define MLP_OFS_MGMT_WDATA 8'h04
`define MLP_OFS_MGMT_RDATA 8'h05
`define MLP_OFS_PORT1 8'h06
`define MLP_OFS_PORT2_IN 8'h07
`define MLP_OFS_RX_STAT 8'h08

`define MLP_PIN_P1_LSB 0
`define MLP_PIN_P2_LSB 2
`define MLP_PSEL_FUNC 2'h1
`define MLP_CMD_REG_LSB 0
`define MLP_CMD_PHY_LSB 5
`define MLP_CMD_READ_BIT 10
`define MLP_CMD_START_BIT 11
`define MLP_P1_OUT_LSB 0
`define MLP_P1_OE_LSB 2
`define MLP_P1_IN_BIT 4

`define MLP_FRAME_ST 2'h1
`define MLP_OP_WRITE 2'h1
`define MLP_OP_READ 2'h2
`define MLP_TA_WRITE 2'h2
`define MLP_TA_IDX 6'h2e
`define MLP_DATA_IDX 6'h30
`define MLP_LAST_IDX 6'h3f

`define MLP_RST_DBG 1'h0
`define MLP_RST_PSEL 2'h0
`define MLP_RST_PORT1 2'h0

`endif

//--- verilog/mlp_pkg.sv
// types shared by the pin block files
// assumes nothing beyond a SystemVerilog compiler
package mlp_pkg;
  typedef enum logic {MLP_MG_IDLE, MLP_MG_SHIFT} mlp_mgmt_state_t;
  typedef logic [1:0] mlp_psel_t;
endpackage

//--- verilog/mlp_rx_capture.sv
// receive-clock side: captures nibbles, pairs them into bytes
// assumes the phy drives nibble, valid and error from rxClk; rxClk may stop
`timescale 1ns/1ps
`include "mlp_consts.svh"

module mlp_rx_capture (
  input wire logic rxClk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0] miiReceiveNibble,
  input wire logic rxDataValid,
  input wire logic rxError,
  output logic [7:0] byteHold,
  output logic errHold,
  output logic byteToggle
);
  logic [1:0] rstSync;
  logic [1:0] enSync;
  logic rxRstN;
  logic [3:0] nibQ;
  logic [3:0] lowNib;
  logic dvQ;
  logic erQ;
  logic half;
  logic errAcc;

  // reset and enable arrive from the ref_clk side
  always_ff @(posedge rxClk)
  begin
    rstSync <= {rstSync[0], rst_n};
    enSync <= {enSync[0], enable};
  end
  assign rxRstN = rstSync[1];

  always_ff @(posedge rxClk)
  begin
    if (!rxRstN)
    begin
      nibQ <= 4'h0;
      dvQ <= 1'h0;
      erQ <= 1'h0;
    end
    else
    begin
      nibQ <= miiReceiveNibble;
      dvQ <= rxDataValid;
      erQ <= rxError;
    end
  end

  // low nibble comes first; an odd nibble at frame end is dropped
  always_ff @(posedge rxClk)
  begin
    if (!rxRstN)
    begin
      lowNib <= 4'h0;
      half <= 1'h0;
      errAcc <= 1'h0;
      byteHold <= 8'h00;
      errHold <= 1'h0;
      byteToggle <= 1'h0;
    end
    else if (dvQ && enSync[1])
    begin
      if (!half)
      begin
        lowNib <= nibQ;
        errAcc <= erQ;
        half <= 1'h1;
      end
      else
      begin
        byteHold <= {nibQ, lowNib};
        errHold <= errAcc | erQ;
        byteToggle <= ~byteToggle;
        half <= 1'h0;
      end
    end
    else
      half <= 1'h0;
  end

  rx_gate_off_a: assert property (@(posedge rxClk) disable iff (!rxRstN)
    !enSync[1] |=> $stable(byteToggle))
    else $error("byte passed while receive pins are general purpose");
  rx_pair_a: assert property (@(posedge rxClk) disable iff (!rxRstN)
    (dvQ && enSync[1] && half) |=> (byteToggle != $past(byteToggle)))
    else $error("second nibble did not complete a byte");
endmodule

//--- bench/mlp_phy_model.sv
// behavioural transceiver: free-running receive clock, nibble source, management responder
// assumes the bench resolves the management data wire with a pull-up when nobody drives
`timescale 1ns/1ps

module mlp_phy_model (
  output logic rxClk,
  output logic [3:0] miiReceiveNibble,
  output logic rxDataValid,
  output logic rxError,
  input wire logic mgmtClockPin,
  input wire logic mgmtDataOe,
  input wire logic mdioWire,
  output logic phyOe,
  output logic phyOut
);
  logic [15:0] mem [32];
  logic [63:0] sh = 64'h0;
  logic [63:0] lastFrame = 64'h0;
  logic isRead = 1'b0;
  logic [4:0] rdReg = 5'h0;
  int rises = 0;
  int falls = 0;
  int frames = 0;

  initial
  begin
    miiReceiveNibble = 4'h0;
    rxDataValid = 1'b0;
    rxError = 1'b0;
    phyOe = 1'b0;
    phyOut = 1'b0;
    for (int i = 0; i < 32; i++)
      mem[i] = 16'hc000 | 16'(i);
  end

  // mii receive clock runs continuously, so the rx reset synchroniser always sees edges
  initial
  begin
    rxClk = 1'b0;
    #3;
    forever #16 rxClk = ~rxClk;
  end

  // low nibble first; valid stays high across the whole byte stream
  task automatic send_byte(input logic [7:0] b, input logic err, input logic last);
    @(posedge rxClk);
    rxDataValid <= 1'b1;
    rxError <= err;
    miiReceiveNibble <= b[3:0];
    @(posedge rxClk);
    miiReceiveNibble <= b[7:4];
    if (last)
    begin
      @(posedge rxClk);
      rxDataValid <= 1'b0;
      rxError <= 1'b0;
      miiReceiveNibble <= ~b[7:4];
    end
  endtask

  task automatic hold_nibble(input logic [3:0] v);
    @(posedge rxClk);
    miiReceiveNibble <= v;
  endtask

  always @(posedge mgmtDataOe)
  begin
    rises = 0;
    falls = 0;
    isRead = 1'b0;
  end

  always @(posedge mgmtClockPin)
  begin
    sh = {sh[62:0], mdioWire};
    rises = rises + 1;
    if (rises == 46)
    begin
      isRead = (sh[11:10] == 2'b10);
      rdReg = sh[4:0];
    end
    if (rises == 64)
    begin
      lastFrame = sh;
      frames = frames + 1;
      if (sh[29:28] == 2'b01)
        mem[sh[22:18]] = sh[15:0];
    end
  end

  // second turnaround bit driven low, then data msb first, launched after the fall
  always @(negedge mgmtClockPin)
  begin
    falls = falls + 1;
    phyOe <= isRead && falls >= 47 && falls <= 63;
    phyOut <= (falls >= 48 && falls <= 63) ? mem[rdReg][63 - falls] : 1'b0;
  end
endmodule

//--- bench/testbench.sv
// self-checking bench for the pin block: leds, management master, receive path
// assumes the transceiver model in its own file and a pull-up on the data wire
`timescale 1ns/1ps

module testbench;
  logic ref_clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [15:0] regWrData;
  logic regWrite, regRead;
  logic [15:0] regRdData;
  logic phySpeed100, phyFullDuplex, phyCollision, phyLinkUp, phyActivity;
  logic debugClockOut, debugDataOut;
  logic speedIndicatorN, duplexCollisionIndicatorN, linkActivityIndicatorN;
  logic mgmtClockPin, mgmtDataOut, mgmtDataOe, phyOe, phyOut;
  logic rxClk, rxDataValid, rxError, rxByteValid, rxByteErr;
  logic [3:0] miiReceiveNibble;
  logic [7:0] rxByte;
  wire mdioWire = mgmtDataOe ? mgmtDataOut : (phyOe ? phyOut : 1'b1);
  int fail_count = 0;
  int compares = 0;
  int runLen = 0;
  int runMin = 999;
  int runMax = 0;
  logic lastMdc = 1'b0;
  logic mdcSeen = 1'b0;
  logic [7:0] rxSeen [$];
  logic errSeen [$];

  mlp_pin_interface #(.BLINK_HALF(8)) u_mlp_pin_interface (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .phySpeed100(phySpeed100), .phyFullDuplex(phyFullDuplex),
    .phyCollision(phyCollision), .phyLinkUp(phyLinkUp), .phyActivity(phyActivity),
    .debugClockOut(debugClockOut), .debugDataOut(debugDataOut),
    .speedIndicatorN(speedIndicatorN), .duplexCollisionIndicatorN(duplexCollisionIndicatorN),
    .linkActivityIndicatorN(linkActivityIndicatorN), .mgmtClockPin(mgmtClockPin),
    .mgmtDataIn(mdioWire), .mgmtDataOut(mgmtDataOut), .mgmtDataOe(mgmtDataOe),
    .rxClk(rxClk), .miiReceiveNibble(miiReceiveNibble), .rxDataValid(rxDataValid),
    .rxError(rxError), .rxByte(rxByte), .rxByteValid(rxByteValid), .rxByteErr(rxByteErr));

  mlp_phy_model u_mlp_phy_model (.rxClk(rxClk), .miiReceiveNibble(miiReceiveNibble),
    .rxDataValid(rxDataValid), .rxError(rxError), .mgmtClockPin(mgmtClockPin),
    .mgmtDataOe(mgmtDataOe), .mdioWire(mdioWire), .phyOe(phyOe), .phyOut(phyOut));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (rxByteValid === 1'b1)
    begin
      rxSeen.push_back(rxByte);
      errSeen.push_back(rxByteErr);
    end
    runLen = runLen + 1;
    if (mgmtClockPin !== lastMdc)
    begin
      if (mdcSeen)
      begin
        runMin = (runLen < runMin) ? runLen : runMin;
        runMax = (runLen > runMax) ? runLen : runMax;
      end
      mdcSeen = 1'b1;
      runLen = 0;
    end
    lastMdc = mgmtClockPin;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // polls the busy flag; a frame that never ends closes the run as failed
  task automatic wait_idle;
    logic [15:0] v;
    v = 16'h0001;
    for (int i = 0; i < 600 && v[0] !== 1'b0; i++)
    begin
      repeat (10) @(posedge ref_clk);
      reg_read(8'h03, v);
    end
    if (v[0] !== 1'b0)
    begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic t_leds;
    logic [15:0] v;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      phySpeed100 <= i[0];
      phyFullDuplex <= i[1];
      phyCollision <= i[2];
      settle();
      check("speed led", speedIndicatorN, !i[0]);
      check("duplex led", duplexCollisionIndicatorN, !(i[1] || i[2]));
    end
    reg_write(8'h01, 16'h0001);
    reg_read(8'h01, v);
    check("debug select", v, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      debugClockOut <= i[0];
      debugDataOut <= i[1];
      phySpeed100 <= i[0];
      phyFullDuplex <= i[1];
      settle();
      check("debug clock pin", speedIndicatorN, i[0]);
      check("debug data pin", duplexCollisionIndicatorN, i[1]);
    end
    reg_write(8'h01, 16'h0000);
    settle();
    check("speed led back", speedIndicatorN, 1'b0);
  endtask

  task automatic t_link;
    int toggles;
    logic last;
    @(posedge ref_clk);
    phyLinkUp <= 1'b1;
    settle();
    check("link steady", linkActivityIndicatorN, 1'b0);
    @(posedge ref_clk);
    phyActivity <= 1'b1;
    toggles = 0;
    last = linkActivityIndicatorN;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      toggles += (linkActivityIndicatorN !== last);
      last = linkActivityIndicatorN;
    end
    check("link blink", toggles >= 3, 1'b1);
    @(posedge ref_clk);
    phyActivity <= 1'b0;
    phyLinkUp <= 1'b0;
    settle();
    check("link down", linkActivityIndicatorN, 1'b1);
  endtask

  task automatic t_port1;
    logic [15:0] v;
    reg_write(8'h06, 16'h000e);
    settle();
    check("port1 pins", {mgmtClockPin, mgmtDataOe, mgmtDataOut}, 3'h3);
    reg_write(8'h06, 16'h0005);
    settle();
    check("port1 pins", {mgmtClockPin, mgmtDataOe}, 2'h2);
    reg_read(8'h06, v);
    check("port1 readback", v, 16'h0015);
    reg_write(8'h06, 16'h0000);
  endtask

  // write, refused restart while busy, then two reads back through the wire
  task automatic t_mgmt;
    logic [15:0] v;
    int n;
    reg_write(8'h02, 16'h0001);
    reg_write(8'h04, 16'hbeef);
    n = u_mlp_phy_model.frames;
    mdcSeen = 1'b0;
    runMin = 999;
    runMax = 0;
    reg_write(8'h03, 16'h0867);
    reg_write(8'h03, 16'h0c09);
    reg_write(8'h04, 16'h1234);
    wait_idle();
    check("frame count", u_mlp_phy_model.frames - n, 1);
    check("write frame", u_mlp_phy_model.lastFrame,
      {32'hffffffff, 2'b01, 2'b01, 5'h03, 5'h07, 2'b10, 16'hbeef});
    check("mdc half period", {runMin[15:0], runMax[15:0]}, {16'd33, 16'd33});
    repeat (100) @(posedge ref_clk);
    check("mdc idle", {mgmtClockPin, mgmtDataOe}, 2'h0);
    reg_write(8'h03, 16'h0c67);
    wait_idle();
    reg_read(8'h05, v);
    check("read data", v, 16'hbeef);
    reg_write(8'h03, 16'h0c69);
    wait_idle();
    reg_read(8'h05, v);
    check("read data", v, 16'hc009);
    check("read frame", u_mlp_phy_model.lastFrame,
      {32'hffffffff, 2'b01, 2'b10, 5'h03, 5'h09, 2'b10, 16'hc009});
  endtask

  task automatic t_rx;
    logic [15:0] v;
    logic [7:0] expB [3];
    logic expE [3];
    expB = '{8'ha5, 8'h3c, 8'hf0};
    expE = '{1'b0, 1'b1, 1'b0};
    reg_write(8'h02, 16'h0005);
    u_mlp_phy_model.send_byte(8'ha5, 1'b0, 1'b0);
    u_mlp_phy_model.send_byte(8'h3c, 1'b1, 1'b0);
    u_mlp_phy_model.send_byte(8'hf0, 1'b0, 1'b1);
    repeat (20) @(posedge ref_clk);
    check("rx bytes", rxSeen.size(), 3);
    for (int i = 0; i < 3; i++)
    begin
      check("rx byte", rxSeen[i], expB[i]);
      check("rx error", errSeen[i], expE[i]);
    end
    reg_read(8'h08, v);
    check("rx status", v, 16'h03f0);
    reg_write(8'h02, 16'h0001);
    u_mlp_phy_model.send_byte(8'h77, 1'b0, 1'b1);
    u_mlp_phy_model.hold_nibble(4'ha);
    repeat (20) @(posedge ref_clk);
    check("rx gpio mode", rxSeen.size(), 3);
    reg_read(8'h07, v);
    check("port2 input", v, 16'h000a);
  endtask

  initial
  begin
    logic [15:0] v;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    {phySpeed100, phyFullDuplex, phyCollision, phyLinkUp, phyActivity} = 5'h00;
    debugClockOut = 1'b0;
    debugDataOut = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check("reset leds",
      {speedIndicatorN, duplexCollisionIndicatorN, linkActivityIndicatorN}, 3'h7);
    check("reset mgmt pins", {mgmtClockPin, mgmtDataOut, mgmtDataOe}, 3'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_read(8'h02, v);
    check("pin select reset", v, 16'h0000);
    reg_read(8'h00, v);
    check("unmapped read", v, 16'h0000);
    reg_read(8'h06, v);
    check("port1 reset", v, 16'h0010);
    t_leds();
    t_link();
    t_port1();
    t_mgmt();
    t_rx();
    print_verdict();
  end
endmodule
